// File: include/exec_pkg.sv
package exec_pkg;

   // Register byte offsets on the APB bus
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_SRC = 8'h04;
   localparam logic [7:0] REG_DST = 8'h08;
   localparam logic [7:0] REG_CNT = 8'h0C;
   localparam logic [7:0] REG_ACC = 8'h10;
   localparam logic [7:0] REG_FBP = 8'h14;
   localparam logic [7:0] REG_STP = 8'h18;
   localparam logic [7:0] REG_FLAGS = 8'h1C;
   localparam logic [7:0] REG_CSEG = 8'h20;
   localparam logic [7:0] REG_IP = 8'h24;
   localparam logic [7:0] REG_OPND = 8'h28;
   localparam logic [7:0] REG_DEPTH = 8'h2C;
   localparam logic [7:0] REG_IDX = 8'h30;
   localparam logic [7:0] REG_MDATA = 8'h34;
   localparam logic [7:0] REG_STATUS = 8'h38;

   // Field positions in flag_word
   localparam int FLG_CY = 0;
   localparam int FLG_Z = 6;
   localparam int FLG_TRACE = 8;
   localparam int FLG_IE = 9;
   localparam int FLG_V = 11;
   localparam int FLG_MD = 15;

   // Field positions in the status and command registers
   localparam int STAT_BUSY = 0;
   localparam int STAT_NATIVE = 1;
   localparam int STAT_TRAP = 2;
   localparam int CMD_MEM_BIT = 4;

   // Reset values
   localparam logic [15:0] FLAGS_RST = 16'h8000;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // Command opcodes
   localparam logic [3:0] OP_BCD_ADD = 4'h1;
   localparam logic [3:0] OP_BCD_SUB = 4'h2;
   localparam logic [3:0] OP_BCD_CMP = 4'h3;
   localparam logic [3:0] OP_ROT_LEFT = 4'h4;
   localparam logic [3:0] OP_ROT_RIGHT = 4'h5;
   localparam logic [3:0] OP_FRAME_BUILD = 4'h6;
   localparam logic [3:0] OP_FRAME_RELEASE = 4'h7;
   localparam logic [3:0] OP_BOUNDS = 4'h8;
   localparam logic [3:0] OP_EMU_ENTER = 4'h9;
   localparam logic [3:0] OP_EMU_LEAVE = 4'hA;
   localparam logic [3:0] OP_NATIVE_CALL = 4'hB;
   localparam logic [3:0] OP_IRQ_RETURN = 4'hC;
   localparam logic [3:0] OP_MEM_READ = 4'hD;
   localparam logic [3:0] OP_MEM_WRITE = 4'hE;

   // Memory and arithmetic constants
   localparam logic [15:0] WORD_BYTES = 16'h0002;
   localparam logic [15:0] VEC_OFF_ADDR = 16'h0014;
   localparam logic [15:0] VEC_SEG_ADDR = 16'h0016;
   localparam logic [4:0] BCD_RADIX = 5'h0A;
   localparam logic [7:0] TWO_DIGITS = 8'h02;
   localparam int MEM_WORDS = 128;

endpackage

// File: include/mem_if.sv
interface mem_if;
   logic [7:0] addr;
   logic we;
   logic [1:0] be;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport host (output addr, output we, output be, output wdata, input rdata);
   modport mem (input addr, input we, input be, input wdata, output rdata);
endinterface

// File: hdl/word_mem.sv
module word_mem
   import exec_pkg::*;
(
   input wire logic pclk,
   mem_if.mem m
);
   logic [15:0] ram [MEM_WORDS];
   logic [15:0] rdata_reg;

   // Read data one cycle after the address, old word on a write
   always_ff @(posedge pclk)
   begin
      rdata_reg <= ram[m.addr[7:1]];
      if (m.we && m.be[0])
         ram[m.addr[7:1]][7:0] <= m.wdata[7:0];
      if (m.we && m.be[1])
         ram[m.addr[7:1]][15:8] <= m.wdata[15:8];
   end

   assign m.rdata = rdata_reg;
endmodule

// File: hdl/bcd_digit_unit.sv
module bcd_digit_unit
   import exec_pkg::*;
(
   input wire logic [3:0] a,
   input wire logic [3:0] b,
   input wire logic cin,
   input wire logic sub,
   output logic [3:0] d,
   output logic cout
);
   logic [4:0] t;

   always_comb
   begin
      if (sub)
      begin
         t = 5'(a) - 5'(b) - 5'(cin);
         cout = t[4];
         d = t[4] ? 4'(t + BCD_RADIX) : t[3:0];
      end
      else
      begin
         t = 5'(a) + 5'(b) + 5'(cin);
         cout = (t >= BCD_RADIX);
         d = cout ? 4'(t - BCD_RADIX) : t[3:0];
      end
   end
endmodule

// File: hdl/bcd_frame_exec.sv
// Functional notes
// (R01) Subtract source string from destination, store
// (R02) Length from digit count; set V, CY, Z
// (R03) Compare subtracts, stores nothing, flags only
// (R04) Rotate byte left by one BCD digit
// (R05) Rotate byte right by one BCD digit
// (R06) Nibbles cycle through accumulator low nibble
// (R07) Frame build: 16-bit local byte count
// (R08) Frame build: 8-bit nesting depth
// (R09) Push old frame base, remember new
// (R10) Copy depth minus one display pointers
// (R11) Nonzero depth also pushes new base
// (R12) Load frame base, reserve local area
// (R13) Release: restore pointers, pop frame base
// (R14) Mode flag: one native, zero emulation
// (R15) Emulation entry clears, return sets flag
// (R16) Native call sets, interrupt return clears
// (R17) Reset and accepted interrupts force native
// (R18) Limits read at operand and operand+2
// (R19) Out-of-range signed index traps, vector 5
// (R20) Trap fetches vector, pushes flags, segment, pointer
// (R21) BCD string add stores sum, sets flags
// (R22) Compare 16-bit values, leave operands intact
//
// Chosen here: the placing of the registers and the APB slave port.
module bcd_frame_exec
   import exec_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic nmi_accept,
   input wire logic irq_accept,
   output logic busy,
   output logic native_mode,
   output logic bounds_trap
);

   typedef enum logic [4:0] {
      ST_IDLE, ST_STR_RS, ST_STR_RD, ST_STR_WR, ST_ROT_RD, ST_ROT_WR,
      ST_FB_PUSH, ST_FB_RD, ST_FB_CP, ST_FB_TOP, ST_FB_END,
      ST_FR_RD, ST_FR_END, ST_BC_RL, ST_BC_RU, ST_BC_CMP,
      ST_TR_VO, ST_TR_VS, ST_TR_P1, ST_TR_P2, ST_TR_P3,
      ST_MEM_RD, ST_MEM_END, ST_MEM_WR
   } state_t;

   typedef struct packed {
      state_t state;
      logic [15:0] src;
      logic [15:0] dst;
      logic [7:0] cnt;
      logic [7:0] acc;
      logic [15:0] fbp;
      logic [15:0] stp;
      logic [15:0] flags;
      logic [15:0] cseg;
      logic [15:0] ip;
      logic [15:0] opnd;
      logic [7:0] depth;
      logic [15:0] idx;
      logic [15:0] mdata;
      logic [7:0] left;
      logic [7:0] rep;
      logic [7:0] sb;
      logic [15:0] off;
      logic [15:0] tmp;
      logic [15:0] walk;
      logic [15:0] wa;
      logic [15:0] wb;
      logic borrow;
      logic zero;
      logic add_mode;
      logic cmp_only;
      logic rot_left;
      logic trap_st;
      logic trap_p;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic busy;
   } st_t;

   localparam st_t ST_RST = '{
      state: ST_IDLE, src: WORD_RST, dst: WORD_RST, cnt: BYTE_RST, acc: BYTE_RST,
      fbp: WORD_RST, stp: WORD_RST, flags: FLAGS_RST, cseg: WORD_RST, ip: WORD_RST,
      opnd: WORD_RST, depth: BYTE_RST, idx: WORD_RST, mdata: WORD_RST,
      left: BYTE_RST, rep: BYTE_RST, sb: BYTE_RST, off: WORD_RST, tmp: WORD_RST,
      walk: WORD_RST, wa: WORD_RST, wb: WORD_RST, borrow: 1'b0, zero: 1'b0,
      add_mode: 1'b0, cmp_only: 1'b0, rot_left: 1'b0, trap_st: 1'b0,
      trap_p: 1'b0, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
      busy: 1'b0};

   st_t r;
   st_t s;

   mem_if mif();

   logic [7:0] m_addr;
   logic m_we;
   logic [1:0] m_be;
   logic [15:0] m_wdata;
   logic [15:0] dptr;
   logic [7:0] dbyte;
   logic [3:0] d0;
   logic [3:0] d1;
   logic c0;
   logic c1;

   // Byte lane of a word, picked by the address bit
   function automatic logic [7:0] lane(input logic [15:0] w, input logic hi);
      return hi ? w[15:8] : w[7:0];
   endfunction

   function automatic logic [1:0] lane_be(input logic hi);
      return hi ? 2'b10 : 2'b01;
   endfunction

   // Result is {new byte, new accumulator nibble}
   function automatic logic [11:0] rot4(input logic [7:0] b, input logic [3:0] a,
                                        input logic left);
      return left ? {b[3:0], a, b[7:4]} : {a, b[7:4], b[3:0]};
   endfunction

   function automatic logic [15:0] dec2(input logic [15:0] p);
      return p - WORD_BYTES;
   endfunction

   word_mem u_mem (
      .pclk(pclk),
      .m(mif.mem)
   );

   assign mif.addr = m_addr;
   assign mif.we = m_we;
   assign mif.be = m_be;
   assign mif.wdata = m_wdata;

   assign dptr = r.dst + r.off;
   assign dbyte = lane(mif.rdata, dptr[0]);

   bcd_digit_unit u_lo (
      .a(dbyte[3:0]),
      .b(r.sb[3:0]),
      .cin(r.borrow),
      .sub(~r.add_mode),
      .d(d0),
      .cout(c0)
   );

   bcd_digit_unit u_hi (
      .a(dbyte[7:4]),
      .b(r.sb[7:4]),
      .cin(c0),
      .sub(~r.add_mode),
      .d(d1),
      .cout(c1)
   );

   always_comb
   begin
      logic [31:0] rd;
      logic hit;
      logic wr;
      logic two;
      logic [7:0] res;
      logic [15:0] sptr;
      logic [11:0] rot;
      rd = 32'h0000_0000;
      hit = 1'b1;
      wr = 1'b0;
      two = (r.left >= TWO_DIGITS);
      res = two ? {d1, d0} : {dbyte[7:4], d0};
      sptr = r.src + r.off;
      rot = rot4(lane(mif.rdata, r.opnd[0]), r.acc[3:0], r.rot_left);
      s = r;
      s.trap_p = 1'b0;
      m_addr = 8'h00;
      m_we = 1'b0;
      m_be = 2'b00;
      m_wdata = 16'h0000;

      // APB: data latched in setup, ready for the access cycle
      unique case (paddr)
         REG_CMD: rd = 32'h0000_0000;
         REG_SRC: rd = {16'h0000, r.src};
         REG_DST: rd = {16'h0000, r.dst};
         REG_CNT: rd = {24'h000000, r.cnt};
         REG_ACC: rd = {24'h000000, r.acc};
         REG_FBP: rd = {16'h0000, r.fbp};
         REG_STP: rd = {16'h0000, r.stp};
         REG_FLAGS: rd = {16'h0000, r.flags};
         REG_CSEG: rd = {16'h0000, r.cseg};
         REG_IP: rd = {16'h0000, r.ip};
         REG_OPND: rd = {16'h0000, r.opnd};
         REG_DEPTH: rd = {24'h000000, r.depth};
         REG_IDX: rd = {16'h0000, r.idx};
         REG_MDATA: rd = {16'h0000, r.mdata};
         REG_STATUS: rd = {29'h0, r.trap_st, r.flags[FLG_MD], r.busy};
         default: hit = 1'b0;
      endcase
      s.pready = psel & ~penable;
      if (psel && !penable)
      begin
         s.prdata = (hit && !pwrite) ? rd : 32'h0000_0000;
         s.pslverr = ~hit;
      end
      wr = psel & penable & r.pready & pwrite & hit;

      // Writes other than the trap clear are dropped while busy so operands stay stable
      if (wr && paddr == REG_STATUS && pwdata[STAT_TRAP])
         s.trap_st = 1'b0;
      if (wr && !r.busy)
      begin
         unique case (paddr)
            REG_SRC: s.src = pwdata[15:0];
            REG_DST: s.dst = pwdata[15:0];
            REG_CNT: s.cnt = pwdata[7:0];
            REG_ACC: s.acc = pwdata[7:0];
            REG_FBP: s.fbp = pwdata[15:0];
            REG_STP: s.stp = pwdata[15:0];
            REG_FLAGS: s.flags = pwdata[15:0];
            REG_CSEG: s.cseg = pwdata[15:0];
            REG_IP: s.ip = pwdata[15:0];
            REG_OPND: s.opnd = pwdata[15:0]; // [R07]
            REG_DEPTH: s.depth = pwdata[7:0]; // [R08]
            REG_IDX: s.idx = pwdata[15:0];
            REG_MDATA: s.mdata = pwdata[15:0];
            default: ;
         endcase
         if (paddr == REG_CMD)
         begin
            s.add_mode = (pwdata[3:0] == OP_BCD_ADD);
            s.cmp_only = (pwdata[3:0] == OP_BCD_CMP); // [R03]
            s.rot_left = (pwdata[3:0] == OP_ROT_LEFT);
            s.off = WORD_RST;
            s.left = r.cnt; // [R02]
            s.borrow = 1'b0;
            s.zero = 1'b1;
            unique case (pwdata[3:0])
               OP_BCD_ADD, OP_BCD_SUB, OP_BCD_CMP:
               begin
                  if (r.cnt == BYTE_RST)
                  begin
                     s.flags[FLG_CY] = 1'b0;
                     s.flags[FLG_Z] = 1'b1;
                     s.flags[FLG_V] = 1'b0;
                  end
                  else
                     s.state = ST_STR_RS;
               end
               OP_ROT_LEFT, OP_ROT_RIGHT:
               begin
                  if (pwdata[CMD_MEM_BIT])
                     s.state = ST_ROT_RD;
                  else
                     {s.opnd[7:0], s.acc[3:0]} =
                        rot4(r.opnd[7:0], r.acc[3:0], s.rot_left); // [R04] [R05] [R06]
               end
               OP_FRAME_BUILD: s.state = ST_FB_PUSH;
               OP_FRAME_RELEASE: s.state = ST_FR_RD;
               OP_BOUNDS: s.state = ST_BC_RL;
               OP_EMU_ENTER: s.flags[FLG_MD] = 1'b0; // [R14] [R15]
               OP_EMU_LEAVE: s.flags[FLG_MD] = 1'b1; // [R15]
               OP_NATIVE_CALL: s.flags[FLG_MD] = 1'b1; // [R16]
               OP_IRQ_RETURN: s.flags[FLG_MD] = 1'b0; // [R16]
               OP_MEM_READ: s.state = ST_MEM_RD;
               OP_MEM_WRITE: s.state = ST_MEM_WR;
               default: ;
            endcase
         end
      end

      unique case (r.state)
         ST_IDLE: ;
         ST_STR_RS:
         begin
            m_addr = sptr[7:0];
            s.state = ST_STR_RD;
         end
         ST_STR_RD:
         begin
            s.sb = lane(mif.rdata, sptr[0]);
            m_addr = dptr[7:0];
            s.state = ST_STR_WR;
         end
         ST_STR_WR:
         begin
            // Low digit first; an odd count leaves the top nibble alone
            m_addr = dptr[7:0];
            m_we = ~r.cmp_only; // [R01] [R03] [R21]
            m_be = lane_be(dptr[0]);
            m_wdata = {res, res};
            s.borrow = two ? c1 : c0;
            s.zero = r.zero & (two ? (res == BYTE_RST) : (d0 == 4'h0));
            s.left = two ? r.left - TWO_DIGITS : BYTE_RST;
            s.off = r.off + 16'h0001;
            if (s.left == BYTE_RST)
            begin
               s.flags[FLG_CY] = s.borrow; // [R02]
               s.flags[FLG_Z] = s.zero;
               s.flags[FLG_V] = 1'b0;
               s.state = ST_IDLE;
            end
            else
               s.state = ST_STR_RS;
         end
         ST_ROT_RD:
         begin
            m_addr = r.opnd[7:0];
            s.state = ST_ROT_WR;
         end
         ST_ROT_WR:
         begin
            m_addr = r.opnd[7:0];
            m_we = 1'b1;
            m_be = lane_be(r.opnd[0]);
            m_wdata = {rot[11:4], rot[11:4]}; // [R04] [R05]
            s.acc[3:0] = rot[3:0]; // [R06]
            s.state = ST_IDLE;
         end
         ST_FB_PUSH:
         begin
            m_addr = 8'(dec2(r.stp));
            m_we = 1'b1;
            m_be = 2'b11;
            m_wdata = r.fbp;
            s.stp = dec2(r.stp); // [R09]
            s.tmp = dec2(r.stp);
            s.walk = r.fbp;
            s.rep = r.depth - 8'h01;
            if (r.depth == BYTE_RST)
               s.state = ST_FB_END;
            else if (r.depth == 8'h01)
               s.state = ST_FB_TOP;
            else
               s.state = ST_FB_RD;
         end
         ST_FB_RD:
         begin
            m_addr = 8'(dec2(r.walk)); // [R10]
            s.walk = dec2(r.walk);
            s.state = ST_FB_CP;
         end
         ST_FB_CP:
         begin
            m_addr = 8'(dec2(r.stp));
            m_we = 1'b1;
            m_be = 2'b11;
            m_wdata = mif.rdata;
            s.stp = dec2(r.stp); // [R10]
            s.rep = r.rep - 8'h01;
            s.state = (r.rep == 8'h01) ? ST_FB_TOP : ST_FB_RD;
         end
         ST_FB_TOP:
         begin
            m_addr = 8'(dec2(r.stp));
            m_we = 1'b1;
            m_be = 2'b11;
            m_wdata = r.tmp; // [R11]
            s.stp = dec2(r.stp);
            s.state = ST_FB_END;
         end
         ST_FB_END:
         begin
            s.fbp = r.tmp; // [R12]
            s.stp = r.stp - r.opnd;
            s.state = ST_IDLE;
         end
         ST_FR_RD:
         begin
            m_addr = r.fbp[7:0];
            s.stp = r.fbp; // [R13]
            s.state = ST_FR_END;
         end
         ST_FR_END:
         begin
            s.fbp = mif.rdata; // [R13]
            s.stp = r.stp + WORD_BYTES;
            s.state = ST_IDLE;
         end
         ST_BC_RL:
         begin
            m_addr = r.opnd[7:0]; // [R18]
            s.state = ST_BC_RU;
         end
         ST_BC_RU:
         begin
            s.wa = mif.rdata;
            m_addr = 8'(r.opnd + WORD_BYTES); // [R18]
            s.state = ST_BC_CMP;
         end
         ST_BC_CMP:
         begin
            // Signed 16-bit compare, index and limits only read
            if ($signed(r.idx) < $signed(r.wa) || $signed(r.idx) > $signed(mif.rdata))
               s.state = ST_TR_VO; // [R19] [R22]
            else
               s.state = ST_IDLE;
         end
         ST_TR_VO:
         begin
            m_addr = VEC_OFF_ADDR[7:0]; // [R20]
            s.trap_st = 1'b1;
            s.trap_p = 1'b1;
            s.state = ST_TR_VS;
         end
         ST_TR_VS:
         begin
            s.wa = mif.rdata;
            m_addr = VEC_SEG_ADDR[7:0]; // [R20]
            s.state = ST_TR_P1;
         end
         ST_TR_P1:
         begin
            s.wb = mif.rdata;
            m_addr = 8'(dec2(r.stp));
            m_we = 1'b1;
            m_be = 2'b11;
            m_wdata = r.flags; // [R20]
            s.stp = dec2(r.stp);
            s.flags[FLG_IE] = 1'b0;
            s.flags[FLG_TRACE] = 1'b0;
            s.state = ST_TR_P2;
         end
         ST_TR_P2:
         begin
            m_addr = 8'(dec2(r.stp));
            m_we = 1'b1;
            m_be = 2'b11;
            m_wdata = r.cseg; // [R20]
            s.stp = dec2(r.stp);
            s.cseg = r.wb;
            s.state = ST_TR_P3;
         end
         ST_TR_P3:
         begin
            m_addr = 8'(dec2(r.stp));
            m_we = 1'b1;
            m_be = 2'b11;
            m_wdata = r.ip; // [R20]
            s.stp = dec2(r.stp);
            s.ip = r.wa;
            s.state = ST_IDLE;
         end
         ST_MEM_RD:
         begin
            m_addr = r.opnd[7:0];
            s.state = ST_MEM_END;
         end
         ST_MEM_END:
         begin
            s.mdata = mif.rdata;
            s.state = ST_IDLE;
         end
         ST_MEM_WR:
         begin
            m_addr = r.opnd[7:0];
            m_we = 1'b1;
            m_be = 2'b11;
            m_wdata = r.mdata;
            s.state = ST_IDLE;
         end
      endcase

      // Accepted interrupt beats any clear in the same cycle
      if (nmi_accept || irq_accept)
         s.flags[FLG_MD] = 1'b1; // [R17]
      s.busy = (s.state != ST_IDLE);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         r <= ST_RST; // [R17]
      else
         r <= s;
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign busy = r.busy;
   assign native_mode = r.flags[FLG_MD]; // [R14]
   assign bounds_trap = r.trap_p;

endmodule

// File: testbench/bcd_frame_exec_props.sv
module bcd_frame_exec_props
   import exec_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic nmi_accept,
   input wire logic irq_accept,
   input wire logic busy,
   input wire logic native_mode,
   input wire logic bounds_trap
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cmd_wr;
   assign cmd_wr = psel && penable && pwrite && pready && paddr == REG_CMD && !busy;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence bnd_cmd;
      cmd_wr && pwdata[3:0] == OP_BOUNDS;
   endsequence
   sequence emu_cmd;
      cmd_wr && pwdata[3:0] == OP_EMU_ENTER && !nmi_accept && !irq_accept;
   endsequence
   apb_ready_a: assert property (pready == $past(psel && !penable))
      else $error("pready not in access cycle");
   unmapped_err_a: assert property (psel && !penable && paddr > REG_STATUS
      |=> pslverr && prdata == 32'h0000_0000) else $error("unmapped not refused");
   mapped_ok_a: assert property (psel && !penable && paddr <= REG_STATUS
      && paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped access refused");
   bounds_busy_a: assert property (bnd_cmd |=> busy [*2])
      else $error("bounds check ended early");
   trap_timing_a: assert property (bounds_trap |-> $past(cmd_wr && pwdata[3:0] == OP_BOUNDS, 5)
      && busy) else $error("trap pulse misplaced");
   trap_pulse_a: assert property (bounds_trap |=> !bounds_trap)
      else $error("trap pulse too long");
   irq_native_a: assert property (nmi_accept || irq_accept |=> native_mode)
      else $error("interrupt kept emulation");
   emu_enter_a: assert property (emu_cmd |=> !native_mode)
      else $error("emulation not entered");
   native_call_a: assert property (cmd_wr && pwdata[3:0] == OP_NATIVE_CALL |=> native_mode)
      else $error("native call failed");
   mode_quick_a: assert property (cmd_wr && pwdata[3:0] inside {[4'h9:4'hC]} |=> !busy)
      else $error("mode op went busy");
   busy_end_a: assert property ($rose(busy) |-> ##[1:600] !busy)
      else $error("command never finished");
endmodule

bind bcd_frame_exec bcd_frame_exec_props i_bcd_frame_exec_props (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .nmi_accept(nmi_accept), .irq_accept(irq_accept), .busy(busy),
   .native_mode(native_mode), .bounds_trap(bounds_trap));

// File: testbench/mem_image.sv
module mem_image;
   timeunit 1ns;
   timeprecision 1ps;
   // Expected system memory, little-endian words, bit0 of address ignored
   logic [15:0] img [0:127];
   task automatic put(input logic [7:0] a, input logic [15:0] d);
      img[a[7:1]] = d;
   endtask
   function automatic logic [15:0] get(input logic [7:0] a);
      return img[a[7:1]];
   endfunction
endmodule

// File: testbench/test_bcd_string_frame_bound_exec.sv
module test_bcd_string_frame_bound_exec
   import exec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic nmi_accept, irq_accept, busy, native_mode, bounds_trap, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int err_count, samples_checked;
   bcd_frame_exec i_bcd_frame_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nmi_accept(nmi_accept), .irq_accept(irq_accept),
      .busy(busy), .native_mode(native_mode), .bounds_trap(bounds_trap));
   mem_image i_mem_image ();
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic complete_run;
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x)
      begin
         err_count++;
         $display("[FAIL] %0t got %h want %h", $time, s, x);
      end
   endtask
   // Answer taken at the edge that samples pready high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n == 20)
         err_count++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0000_0000);
      chk(q, x);
   endtask
   task automatic run(input logic [31:0] op);
      int n;
      wr(REG_CMD, op);
      n = 0;
      @(negedge pclk);
      while (busy !== 1'b0 && n < 1000)
      begin
         @(negedge pclk);
         n++;
      end
      if (n == 1000)
         err_count++;
   endtask
   task automatic mw(input logic [7:0] a, input logic [15:0] d);
      wr(REG_MDATA, {16'h0000, d});
      wr(REG_OPND, {24'h000000, a});
      run(OP_MEM_WRITE);
      i_mem_image.put(a, d);
   endtask
   task automatic mchk(input logic [7:0] a);
      wr(REG_OPND, {24'h000000, a});
      run(OP_MEM_READ);
      rdc(REG_MDATA, {16'h0000, i_mem_image.get(a)});
   endtask
   task automatic t_bcd;
      mw(8'h10, 16'h1234);
      mw(8'h20, 16'h0235);
      wr(REG_SRC, 32'h0000_0020);
      wr(REG_DST, 32'h0000_0010);
      wr(REG_CNT, 32'h0000_0004);
      run(OP_BCD_SUB);
      i_mem_image.put(8'h10, 16'h0999);
      mchk(8'h10);
      rdc(REG_FLAGS, 32'h0000_8000);
      wr(REG_SRC, 32'h0000_0010);
      wr(REG_DST, 32'h0000_0020);
      run(OP_BCD_CMP);
      rdc(REG_FLAGS, 32'h0000_8001);
      mchk(8'h20);
      wr(REG_DST, 32'h0000_0010);
      run(OP_BCD_CMP);
      rdc(REG_FLAGS, 32'h0000_8040);
      run(OP_BCD_ADD);
      i_mem_image.put(8'h10, 16'h1998);
      mchk(8'h10);
   endtask
   task automatic t_rot;
      wr(REG_ACC, 32'h0000_0007);
      wr(REG_OPND, 32'h0000_0012);
      run(OP_ROT_LEFT);
      rdc(REG_OPND, 32'h0000_0027);
      rdc(REG_ACC, 32'h0000_0001);
      run(OP_ROT_RIGHT);
      rdc(REG_OPND, 32'h0000_0012);
      rdc(REG_ACC, 32'h0000_0007);
      mw(8'h30, 16'h0056);
      wr(REG_OPND, 32'h0000_0030);
      run({27'h0, 1'b1, OP_ROT_LEFT});
      i_mem_image.put(8'h30, 16'h0067);
      mchk(8'h30);
      rdc(REG_ACC, 32'h0000_0005);
   endtask
   task automatic t_frame;
      mw(8'h5E, 16'hAAAA);
      wr(REG_FBP, 32'h0000_0060);
      wr(REG_STP, 32'h0000_0050);
      wr(REG_OPND, 32'h0000_0006);
      wr(REG_DEPTH, 32'h0000_0002);
      run(OP_FRAME_BUILD);
      rdc(REG_FBP, 32'h0000_004E);
      rdc(REG_STP, 32'h0000_0044);
      i_mem_image.put(8'h4E, 16'h0060);
      i_mem_image.put(8'h4C, 16'hAAAA);
      i_mem_image.put(8'h4A, 16'h004E);
      mchk(8'h4E);
      mchk(8'h4C);
      mchk(8'h4A);
      run(OP_FRAME_RELEASE);
      rdc(REG_FBP, 32'h0000_0060);
      rdc(REG_STP, 32'h0000_0050);
   endtask
   task automatic t_bounds;
      mw(8'h70, 16'hFFFE);
      mw(8'h72, 16'h0005);
      mw(8'h14, 16'h1111);
      mw(8'h16, 16'h2222);
      // Upper limit itself is inside the range
      wr(REG_IDX, 32'h0000_0005);
      wr(REG_OPND, 32'h0000_0070);
      run(OP_BOUNDS);
      rdc(REG_STATUS, 32'h0000_0002);
      wr(REG_IDX, 32'h0000_FFFD);
      wr(REG_FLAGS, 32'h0000_8301);
      wr(REG_CSEG, 32'h0000_3333);
      wr(REG_IP, 32'h0000_4444);
      wr(REG_STP, 32'h0000_0040);
      run(OP_BOUNDS);
      rdc(REG_STATUS, 32'h0000_0006);
      rdc(REG_STP, 32'h0000_003A);
      rdc(REG_CSEG, 32'h0000_2222);
      rdc(REG_IP, 32'h0000_1111);
      rdc(REG_FLAGS, 32'h0000_8001);
      rdc(REG_IDX, 32'h0000_FFFD);
      i_mem_image.put(8'h3E, 16'h8301);
      i_mem_image.put(8'h3C, 16'h3333);
      i_mem_image.put(8'h3A, 16'h4444);
      mchk(8'h3E);
      mchk(8'h3C);
      mchk(8'h3A);
      mchk(8'h70);
      wr(REG_STATUS, 32'h0000_0004);
      rdc(REG_STATUS, 32'h0000_0002);
   endtask
   task automatic t_mode;
      logic [3:0] ops [5] = '{OP_EMU_ENTER, OP_EMU_LEAVE, OP_EMU_ENTER, OP_NATIVE_CALL,
         OP_IRQ_RETURN};
      for (int i = 0; i < 5; i++)
      begin
         run({28'h0, ops[i]});
         chk({31'h0, native_mode}, {31'h0, ops[i] inside {OP_EMU_LEAVE, OP_NATIVE_CALL}});
      end
      for (int i = 0; i < 2; i++)
      begin
         run({28'h0, OP_EMU_ENTER});
         @(posedge pclk);
         nmi_accept <= (i == 0);
         irq_accept <= (i == 1);
         @(posedge pclk);
         nmi_accept <= 1'b0;
         irq_accept <= 1'b0;
         @(negedge pclk);
         chk({31'h0, native_mode}, 32'h0000_0001);
      end
   endtask
   initial
   begin
      {psel, penable, pwrite, nmi_accept, irq_accept} = 5'b00000;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdc(REG_FLAGS, 32'h0000_8000);
      rdc(REG_STATUS, 32'h0000_0002);
      t_bcd;
      t_rot;
      t_frame;
      t_bounds;
      t_mode;
      xfer(1'b0, 8'h3C, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
      complete_run;
   end
   // Whole sequence needs under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_count++;
      complete_run;
   end
endmodule
